// ===== ucic_pkg.sv
package ucic_pkg;
	// register offsets on the channel's 4-bit address bus
	localparam logic [3:0] ADDR_HOLDING = 4'h0; // rx holding read, tx holding write
	localparam logic [3:0] ADDR_MASK = 4'h1;
	localparam logic [3:0] ADDR_SOURCE = 4'h2; // source on read, fifo control on write
	localparam logic [3:0] ADDR_LINE_STAT = 4'h5;
	localparam logic [3:0] ADDR_MODEM_STAT = 4'h6;

	// mask register fields
	localparam int MASK_RX_RDY = 0;
	localparam int MASK_TX_RDY = 1;
	localparam int MASK_LINE = 2;
	localparam int MASK_MODEM = 3;
	localparam int MASK_XOFF = 5;
	localparam int MASK_RTS = 6;
	localparam int MASK_CTS = 7;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] MASK_BASE_BITS = 8'h0f; // always writable part

	// fifo control fields
	localparam int FCTL_ENABLE = 0;
	localparam int FCTL_RX_RST = 1;
	localparam int FCTL_TX_RST = 2;
	localparam int FCTL_KEEP_LO = 3; // bits 7:3 stored for datapath
	localparam logic [4:0] FCTL_KEEP_RESET = 5'h00;

	// enhanced feature fields
	localparam int ENH_UNLOCK = 4;
	localparam int ENH_AUTO_RX = 6;
	localparam int ENH_AUTO_TX = 7;

	// source codes, bits 5..0, highest priority first
	localparam logic [5:0] SRC_LINE = 6'h06;
	localparam logic [5:0] SRC_RX_RDY = 6'h04;
	localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
	localparam logic [5:0] SRC_TX_RDY = 6'h02;
	localparam logic [5:0] SRC_MODEM = 6'h00;
	localparam logic [5:0] SRC_XOFF_SPEC = 6'h10;
	localparam logic [5:0] SRC_FLOW = 6'h20;
	localparam logic [5:0] SRC_NONE = 6'h01;

	// receive time-out in bit times: four characters plus twelve bits
	localparam int TOUT_CHARS = 4;
	localparam int TOUT_EXTRA_BITS = 12;
endpackage // ucic_pkg

// ===== ucic_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - fifo mode: rx interrupt follows trigger level
// - data ready set on push, cleared empty
// - line status bits assembled as listed
// - mask bit 0 gates receive ready
// - mask bit 1 gates transmit ready
// - mask bit 2 gates line status errors
// - mask bit 3 gates modem status deltas
// - mask bits 7:5 writable only with enhancement
// - auto tx flow: input rise interrupt
// - auto rx flow: output rise interrupt
// - source read shows highest pending only
// - time-out after 4 chars plus 12 bits
// - line read clears line status, modem read clears flow interrupts
// - source read or tx write clears tx
// - xoff and special character interrupts
// - half duplex: tx ready on empty transmitter
// - source bits 5:1 encode priority level
// - bit 0 low while anything pending
// - source bits 7:6 mirror fifo enable
// - fifo control needs bit 0 set
// - rx fifo reset pulse, self clearing
// - tx fifo reset pulse, self clearing
module ucic_ctrl #(
	parameter int TOUT_W = 8
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [3:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] enh_feat_i,
	input wire logic flow_sel_i,
	input wire logic half_duplex_i,
	input wire logic rx_push_i,
	input wire logic rx_empty_i,
	input wire logic rx_trig_hit_i,
	input wire logic [3:0] rx_err_i,
	input wire logic rx_fifo_err_i,
	input wire logic bit_tick_i,
	input wire logic [3:0] char_bits_i,
	input wire logic tx_hold_empty_i,
	input wire logic tx_trig_below_i,
	input wire logic tx_all_empty_i,
	input wire logic [3:0] modem_delta_i,
	input wire logic cts_i,
	input wire logic dsr_i,
	input wire logic rts_drv_i,
	input wire logic dtr_drv_i,
	input wire logic xoff_det_i,
	input wire logic xon_det_i,
	input wire logic special_det_i,
	output logic fifo_en_o,
	output logic [4:0] fifo_cfg_o,
	output logic rx_fifo_rst_o,
	output logic tx_fifo_rst_o,
	output logic data_ready_o,
	output logic irq_o
);
	typedef struct packed {
		logic [7:0] mask;
		logic fifo_en;
		logic [4:0] cfg;
		logic rx_rst;
		logic tx_rst;
		logic ready;
		logic [3:0] err;
		logic line_f;
		logic tx_f;
		logic tx_src_q; // previous tx-ready source level
		logic to_f;
		logic [TOUT_W-1:0] to_cnt;
		logic xoff_f;
		logic spec_f;
		logic flow_in_f;
		logic flow_out_f;
		logic flow_in_q;
		logic flow_out_q;
		logic [7:0] rdata;
		logic irq;
	} ucic_state_s;

	ucic_state_s q, d;
	logic rx_rdy_lvl, modem_lvl, pend;
	logic [5:0] src;
	logic [7:0] line_stat, src_reg;
	logic rd_src, rd_line, rd_modem, rd_hold, wr_hold, wr_mask, wr_fctl;
	logic tx_src, flow_in_lvl, flow_out_lvl, tx_set, line_set, to_hit;
	logic [TOUT_W-1:0] to_limit;

	////////////////////////////////////////////////////////////////////////////
	// address decode and derived levels
	always_comb
	begin
		rd_src = rd_i && addr_i == ucic_pkg::ADDR_SOURCE;
		rd_line = rd_i && addr_i == ucic_pkg::ADDR_LINE_STAT;
		rd_modem = rd_i && addr_i == ucic_pkg::ADDR_MODEM_STAT;
		rd_hold = rd_i && addr_i == ucic_pkg::ADDR_HOLDING;
		wr_hold = wr_i && addr_i == ucic_pkg::ADDR_HOLDING;
		wr_mask = wr_i && addr_i == ucic_pkg::ADDR_MASK;
		wr_fctl = wr_i && addr_i == ucic_pkg::ADDR_SOURCE;
		// trigger in fifo mode, holding register otherwise
		rx_rdy_lvl = q.mask[ucic_pkg::MASK_RX_RDY] && (q.fifo_en ? rx_trig_hit_i : q.ready);
		modem_lvl = q.mask[ucic_pkg::MASK_MODEM] && (|modem_delta_i);
		// half duplex waits for the whole transmitter to drain
		tx_src = half_duplex_i ? tx_all_empty_i : (tx_hold_empty_i || tx_trig_below_i);
		flow_in_lvl = flow_sel_i ? dsr_i : cts_i;
		flow_out_lvl = flow_sel_i ? dtr_drv_i : rts_drv_i;
		// transmit ready fires on the rising edge of its source
		tx_set = tx_src && !q.tx_src_q;
		// a character arriving with any error bit
		line_set = rx_push_i && (|rx_err_i);
		to_limit = TOUT_W'(ucic_pkg::TOUT_CHARS) * TOUT_W'(char_bits_i)
			+ TOUT_W'(ucic_pkg::TOUT_EXTRA_BITS);
		to_hit = bit_tick_i && q.to_cnt >= to_limit - TOUT_W'(1);
	end

	////////////////////////////////////////////////////////////////////////////
	// priority encoder; lower sources stay queued behind the reported one
	always_comb
	begin
		if (q.mask[ucic_pkg::MASK_LINE] && q.line_f)
			src = ucic_pkg::SRC_LINE;
		else if (rx_rdy_lvl)
			src = ucic_pkg::SRC_RX_RDY;
		else if (q.mask[ucic_pkg::MASK_RX_RDY] && q.to_f)
			src = ucic_pkg::SRC_TIMEOUT;
		else if (q.mask[ucic_pkg::MASK_TX_RDY] && q.tx_f)
			src = ucic_pkg::SRC_TX_RDY;
		else if (modem_lvl)
			src = ucic_pkg::SRC_MODEM;
		else if (q.mask[ucic_pkg::MASK_XOFF] && (q.xoff_f || q.spec_f))
			src = ucic_pkg::SRC_XOFF_SPEC;
		else if ((q.mask[ucic_pkg::MASK_CTS] && q.flow_in_f)
			|| (q.mask[ucic_pkg::MASK_RTS] && q.flow_out_f))
			src = ucic_pkg::SRC_FLOW;
		else
			src = ucic_pkg::SRC_NONE;
		pend = !src[0];
		// fifo enable mirrored in the top two bits
		src_reg = {{2{q.fifo_en}}, src};
		line_stat = {rx_fifo_err_i, tx_all_empty_i, tx_hold_empty_i, q.err, q.ready};
	end

	////////////////////////////////////////////////////////////////////////////
	// next state; in every sticky flag a set outranks a same-cycle clear
	always_comb
	begin
		d = q;
		d.rx_rst = 1'b0;
		d.tx_rst = 1'b0;
		d.tx_src_q = tx_src;
		d.flow_in_q = flow_in_lvl;
		d.flow_out_q = flow_out_lvl;
		d.irq = pend;
		// upper mask bits locked without enhanced mode; bit 4 reserved
		if (wr_mask)
		begin
			d.mask[3:0] = wdata_i[3:0];
			if (enh_feat_i[ucic_pkg::ENH_UNLOCK])
				d.mask[7:5] = wdata_i[7:5];
		end
		// without bit 0 only the disable takes effect
		if (wr_fctl)
		begin
			d.fifo_en = wdata_i[ucic_pkg::FCTL_ENABLE];
			if (wdata_i[ucic_pkg::FCTL_ENABLE])
			begin
				d.cfg = wdata_i[7:ucic_pkg::FCTL_KEEP_LO];
				d.rx_rst = wdata_i[ucic_pkg::FCTL_RX_RST];
				d.tx_rst = wdata_i[ucic_pkg::FCTL_TX_RST];
			end
		end
		// data ready until the fifo runs empty
		if (rx_push_i)
			d.ready = 1'b1;
		else if (rx_empty_i)
			d.ready = 1'b0;
		if (rx_push_i)
			d.err = rx_err_i;
		if (line_set)
			d.line_f = 1'b1;
		else if (rd_line)
			d.line_f = 1'b0;
		// tx ready cleared by tx write or by reading it as source
		if (tx_set)
			d.tx_f = 1'b1;
		else if (wr_hold || (rd_src && src == ucic_pkg::SRC_TX_RDY))
			d.tx_f = 1'b0;
		// time-out timer restarts on each character or rx read
		if (rx_push_i || rd_hold || !q.fifo_en || rx_empty_i)
			d.to_cnt = '0;
		else if (bit_tick_i && !to_hit)
			d.to_cnt = q.to_cnt + TOUT_W'(1);
		if (to_hit && q.fifo_en && !rx_empty_i && !rx_push_i)
			d.to_f = 1'b1;
		else if (rd_hold)
			d.to_f = 1'b0;
		// xoff clears on xon or source read; special on next char
		if (xoff_det_i)
			d.xoff_f = 1'b1;
		else if (xon_det_i || (rd_src && src == ucic_pkg::SRC_XOFF_SPEC))
			d.xoff_f = 1'b0;
		if (special_det_i)
			d.spec_f = 1'b1;
		else if (rx_push_i || (rd_src && src == ucic_pkg::SRC_XOFF_SPEC))
			d.spec_f = 1'b0;
		// flow input rise under auto tx flow control
		if (enh_feat_i[ucic_pkg::ENH_AUTO_TX] && flow_in_lvl && !q.flow_in_q)
			d.flow_in_f = 1'b1;
		else if (rd_modem)
			d.flow_in_f = 1'b0;
		// flow output rise under auto rx flow control
		if (enh_feat_i[ucic_pkg::ENH_AUTO_RX] && flow_out_lvl && !q.flow_out_q)
			d.flow_out_f = 1'b1;
		else if (rd_modem)
			d.flow_out_f = 1'b0;
		// read data, registered one cycle after the strobe
		unique case (addr_i)
			ucic_pkg::ADDR_MASK: d.rdata = q.mask;
			ucic_pkg::ADDR_SOURCE: d.rdata = src_reg;
			ucic_pkg::ADDR_LINE_STAT: d.rdata = line_stat;
			default: d.rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			q <= '0;
			q.mask <= ucic_pkg::MASK_RESET;
			q.cfg <= ucic_pkg::FCTL_KEEP_RESET;
		end
		else
			q <= d;
	end

	// outputs straight from the state register
	assign rdata_o = q.rdata;
	assign fifo_en_o = q.fifo_en;
	assign fifo_cfg_o = q.cfg;
	assign rx_fifo_rst_o = q.rx_rst;
	assign tx_fifo_rst_o = q.tx_rst;
	assign data_ready_o = q.ready;
	assign irq_o = q.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_rx_reset_cmd;
		wr_fctl && wdata_i[ucic_pkg::FCTL_ENABLE] && wdata_i[ucic_pkg::FCTL_RX_RST];
	endsequence
	sequence s_one_pulse;
		rx_fifo_rst_o ##1 !rx_fifo_rst_o;
	endsequence

	a_rx_reset_pulse: assert property (s_rx_reset_cmd |=> s_one_pulse)
		else $error("rx fifo reset not a single pulse");
	a_fctl_ignore: assert property (wr_fctl && !wdata_i[0] |=> !fifo_en_o && $stable(fifo_cfg_o)
		&& !rx_fifo_rst_o && !tx_fifo_rst_o)
		else $error("fifo control bits taken without enable");
	a_mask_lock: assert property (wr_mask && !enh_feat_i[4]
		|=> q.mask[7:5] == $past(q.mask[7:5]) && q.mask[4] == 1'b0)
		else $error("locked mask bits changed");
	a_irq_follow: assert property (pend |=> irq_o)
		else $error("irq missing while pending");
	a_src_idle: assert property (rd_src && !pend |=> rdata_o[5:0] == 6'h01)
		else $error("idle code wrong");
	a_src_fifo_bits: assert property (rd_src |=> rdata_o[7:6] == {2{$past(q.fifo_en)}})
		else $error("fifo bits in source wrong");
	a_ready_set: assert property (rx_push_i |=> data_ready_o)
		else $error("data ready not set on push");
	a_line_clear: assert property (rd_line && !line_set |=> !q.line_f)
		else $error("line status flag not cleared");
	a_tx_clear: assert property (wr_hold && !tx_set |=> !q.tx_f)
		else $error("tx ready not cleared by write");
	a_line_first: assert property (q.mask[2] && q.line_f |-> src == 6'h06)
		else $error("line status not top priority");
endmodule // ucic_ctrl

// ===== ucic_host.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// host side of the channel register bus, one access at a time
module ucic_host (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [3:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] wdata_o
);
	// bus idle until the first access
	initial
	begin
		addr_o = 4'h0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end

	// host access format, read or write
	// strobe held one edge; data is inverted once released so stale bytes never pass
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		#1;
		addr_o = a;
		wdata_o = d;
		rd_o = !w;
		wr_o = w;
		@(posedge clk_i);
		#1;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = ~d;
		q = rdata_i;
	endtask
endmodule // ucic_host

// ===== ucic_ctrl_tb.sv
`timescale 1ns/10ps
module ucic_ctrl_tb;
	localparam logic [3:0] A_SRC = ucic_pkg::ADDR_SOURCE;
	localparam logic [3:0] A_MSK = ucic_pkg::ADDR_MASK;
	localparam logic [3:0] A_HOLD = ucic_pkg::ADDR_HOLDING;
	localparam logic [3:0] A_LINE = ucic_pkg::ADDR_LINE_STAT;
	localparam logic [3:0] A_MDM = ucic_pkg::ADDR_MODEM_STAT;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] addr, rx_err, char_bits, mdm_d;
	logic rd, wr, flow_sel, hdx, push, rx_empty, trig, tick;
	logic hold_e, all_e, tx_below, fifo_err;
	logic cts, dsr, rts, dtr, xoff, xon, spec;
	logic fifo_en, rx_rst, tx_rst, dready, irq, fifo_m;
	logic [7:0] wdata, rdata, enh, q, lfsr, mask_m;
	logic [4:0] cfg;
	int failures, checks, i;

	always #2 clk_i = ~clk_i;

	ucic_host u_ucic_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .rd_o(rd),
		.wr_o(wr), .wdata_o(wdata));
	// every status input is driven by the bench, none tied
	ucic_ctrl u_ucic_ctrl (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .rd_i(rd),
		.wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .enh_feat_i(enh), .flow_sel_i(flow_sel),
		.half_duplex_i(hdx), .rx_push_i(push), .rx_empty_i(rx_empty),
		.rx_trig_hit_i(trig), .rx_err_i(rx_err), .rx_fifo_err_i(fifo_err), .bit_tick_i(tick),
		.char_bits_i(char_bits), .tx_hold_empty_i(hold_e), .tx_trig_below_i(tx_below),
		.tx_all_empty_i(all_e), .modem_delta_i(mdm_d), .cts_i(cts), .dsr_i(dsr),
		.rts_drv_i(rts), .dtr_drv_i(dtr), .xoff_det_i(xoff), .xon_det_i(xon),
		.special_det_i(spec), .fifo_en_o(fifo_en), .fifo_cfg_o(cfg),
		.rx_fifo_rst_o(rx_rst), .tx_fifo_rst_o(tx_rst), .data_ready_o(dready), .irq_o(irq));

	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		u_ucic_host.acc(1'b0, a, 8'h00, q);
		cmp(q, exp);
	endtask

	// read whose side effect matters, value not judged
	task automatic rdx(input logic [3:0] a);
		u_ucic_host.acc(1'b0, a, 8'h00, q);
		step(2);
	endtask

	// model of the mask register: bits 7:5 locked unless unlocked, bit 4 reserved
	task automatic wmask(input logic [7:0] d);
		u_ucic_host.acc(1'b1, A_MSK, d, q);
		mask_m = {enh[4] ? d[7:5] : mask_m[7:5], 1'b0, d[3:0]};
	endtask

	// expected source byte: fifo bits above the code
	task automatic pend(input logic [5:0] c);
		step(3);
		rdc(A_SRC, {fifo_m ? 2'b11 : 2'b00, c});
	endtask

	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	////////////////////////////////////////////////////////////////
	// watchdog: whole sequence needs well under 1000 cycles
	initial
	begin
		#20000;
		failures++;
		print_verdict();
	end

	initial
	begin
		{flow_sel, hdx, push, trig, tick, hold_e, all_e, tx_below, fifo_err} = '0;
		{cts, dsr, rts, dtr, xoff, xon, spec} = '0;
		{rx_err, mdm_d, enh, mask_m, fifo_m} = '0;
		rx_empty = 1'b1;
		char_bits = 4'h8;
		lfsr = 8'h36;
		step(2);
		reset_i = 1'b0;
		pend(ucic_pkg::SRC_NONE);
		cmp({7'h0, irq}, 8'h00);
		rdc(A_MSK, ucic_pkg::MASK_RESET);
		for (i = 0; i < 6; i++)
		begin
			lfsr = nxt(lfsr);
			enh = {3'h0, lfsr[0], 4'h0};
			wmask(lfsr);
			rdc(A_MSK, mask_m);
		end
		enh = 8'hd0;
		wmask(8'h00);
		u_ucic_host.acc(1'b1, A_SRC, 8'h03, q);
		cmp({6'h0, fifo_en, rx_rst}, 8'h03);
		step(1);
		cmp({7'h0, rx_rst}, 8'h00);
		u_ucic_host.acc(1'b1, A_SRC, 8'h04, q);
		cmp({6'h0, fifo_en, tx_rst}, 8'h00);
		pend(ucic_pkg::SRC_NONE);
		u_ucic_host.acc(1'b1, A_SRC, 8'hf5, q);
		fifo_m = 1'b1;
		cmp({fifo_en, tx_rst, 1'b0, cfg}, 8'hde);
		step(1);
		cmp({7'h0, tx_rst}, 8'h00);
		pend(ucic_pkg::SRC_NONE);
		// polled mode: errored char with mask clear raises nothing
		all_e = 1'b1;
		rx_err = 4'h2;
		rx_empty = 1'b0;
		push = 1'b1;
		step(1);
		push = 1'b0;
		step(3);
		cmp({6'h0, irq, dready}, 8'h01);
		rx_empty = 1'b1;
		fifo_err = 1'b1;
		step(2);
		u_ucic_host.acc(1'b0, A_LINE, 8'h00, q);
		cmp(q, 8'hc4);
		fifo_err = 1'b0;
		wmask(8'h04);
		rx_empty = 1'b0;
		push = 1'b1;
		step(1);
		push = 1'b0;
		pend(ucic_pkg::SRC_LINE);
		cmp({7'h0, irq}, 8'h01);
		rdx(A_LINE);
		cmp({7'h0, irq}, 8'h00);
		// receive trigger outranks transmit ready
		wmask(8'h03);
		hold_e = 1'b1;
		trig = 1'b1;
		pend(ucic_pkg::SRC_RX_RDY);
		trig = 1'b0;
		pend(ucic_pkg::SRC_TX_RDY);
		pend(ucic_pkg::SRC_NONE);
		hold_e = 1'b0;
		step(1);
		hold_e = 1'b1;
		step(3);
		cmp({7'h0, irq}, 8'h01);
		u_ucic_host.acc(1'b1, A_HOLD, 8'h55, q);
		step(2);
		cmp({7'h0, irq}, 8'h00);
		hdx = 1'b1;
		all_e = 1'b0;
		step(1);
		all_e = 1'b1;
		pend(ucic_pkg::SRC_TX_RDY);
		hdx = 1'b0;
		rdx(A_SRC);
		// transmit level below trigger raises it too
		hold_e = 1'b0;
		step(1);
		tx_below = 1'b1;
		pend(ucic_pkg::SRC_TX_RDY);
		pend(ucic_pkg::SRC_NONE);
		wmask(8'h08);
		mdm_d = 4'h1;
		pend(ucic_pkg::SRC_MODEM);
		mdm_d = 4'h0;
		rdx(A_MDM);
		pend(ucic_pkg::SRC_NONE);
		// time-out: 4 chars of 8 bits plus 12 bit times
		wmask(8'h01);
		for (i = 0; i < 44; i++)
		begin
			tick = 1'b1;
			step(1);
			tick = 1'b0;
			step(1);
			if (i == 42)
				pend(ucic_pkg::SRC_NONE);
		end
		pend(ucic_pkg::SRC_TIMEOUT);
		rdx(A_HOLD);
		pend(ucic_pkg::SRC_NONE);
		rx_empty = 1'b1;
		rx_err = 4'h0;
		// xoff: cleared by source read, then by xon alone
		wmask(8'h20);
		xoff = 1'b1;
		step(1);
		xoff = 1'b0;
		pend(ucic_pkg::SRC_XOFF_SPEC);
		pend(ucic_pkg::SRC_NONE);
		xoff = 1'b1;
		step(1);
		xoff = 1'b0;
		step(2);
		cmp({7'h0, irq}, 8'h01);
		xon = 1'b1;
		step(1);
		xon = 1'b0;
		pend(ucic_pkg::SRC_NONE);
		// special: cleared by source read, then by next character
		spec = 1'b1;
		step(1);
		spec = 1'b0;
		pend(ucic_pkg::SRC_XOFF_SPEC);
		pend(ucic_pkg::SRC_NONE);
		spec = 1'b1;
		step(1);
		spec = 1'b0;
		step(2);
		cmp({7'h0, irq}, 8'h01);
		push = 1'b1;
		step(1);
		push = 1'b0;
		pend(ucic_pkg::SRC_NONE);
		// flow input rise for both selections, then output rise for both
		wmask(8'hc0);
		for (i = 0; i < 4; i++)
		begin
			flow_sel = i[0];
			{dtr, rts, dsr, cts} = 4'h1 << i;
			pend(ucic_pkg::SRC_FLOW);
			rdx(A_MDM);
			pend(ucic_pkg::SRC_NONE);
			{dtr, rts, dsr, cts} = 4'h0;
			flow_sel = 1'b0;
			step(1);
		end
		// fifos off: receive ready follows the holding register
		u_ucic_host.acc(1'b1, A_SRC, 8'h00, q);
		fifo_m = 1'b0;
		wmask(8'h01);
		rx_empty = 1'b0;
		push = 1'b1;
		step(1);
		push = 1'b0;
		pend(ucic_pkg::SRC_RX_RDY);
		rx_empty = 1'b1;
		pend(ucic_pkg::SRC_NONE);
		print_verdict();
	end
endmodule // ucic_ctrl_tb
